// ---- rtl/ohp_pkg.sv ----
package ohp_pkg;

  // Channel and register space
  localparam int NUM_CH       = 8;
  localparam int NUM_REG      = 16;
  localparam int IDX_LSB      = 0;
  localparam int IDX_MSB      = 3;
  localparam int CH_LSB       = 4;
  localparam int CH_MSB       = 6;
  localparam int GLOBAL_BIT   = 7;

  // Per-channel register indices, classic layout first
  localparam logic [3:0] REG_HOLD       = 4'h0;
  localparam logic [3:0] REG_INT_EN     = 4'h1;
  localparam logic [3:0] REG_INT_ID     = 4'h2;
  localparam logic [3:0] REG_LINE_CTL   = 4'h3;
  localparam logic [3:0] REG_MODEM_CTL  = 4'h4;
  localparam logic [3:0] REG_LINE_STAT  = 4'h5;
  localparam logic [3:0] REG_MODEM_STAT = 4'h6;
  localparam logic [3:0] REG_SCRATCH    = 4'h7;
  localparam logic [3:0] REG_FEAT_CTL   = 4'h8;
  localparam logic [3:0] REG_ENH_FEAT   = 4'h9;
  localparam logic [3:0] REG_TX_LEVEL   = 4'ha;
  localparam logic [3:0] REG_RX_LEVEL   = 4'hb;

  // Global register indices
  localparam logic [3:0] GREG_INT_SRC   = 4'h0;

  // Field positions
  localparam int FEATURE_CONTROL_REG_IR_INV_BIT  = 4;
  localparam int FEATURE_CONTROL_REG_DIR_CTL_BIT = 5;
  localparam int EFR_AUTO_OUT_BIT = 6;
  localparam int EFR_AUTO_IN_BIT  = 7;
  localparam int MCR_DTR_BIT      = 0;
  localparam int MCR_RTS_BIT      = 1;
  localparam int MCR_PAIR_BIT     = 2;
  localparam int MCR_IR_EN_BIT    = 6;
  localparam int LSR_RX_RDY_BIT   = 0;
  localparam int LSR_TX_ROOM_BIT  = 5;
  localparam int LSR_TX_EMPTY_BIT = 6;

  // Reset values and FIFO sizing
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam int         LVL_W      = 7;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam logic [6:0] LVL_ZERO   = 7'h00;
  localparam logic [6:0] LVL_ONE    = 7'h01;

  typedef logic [NUM_CH-1:0][NUM_REG-1:0][7:0] ohp_bank_t;

endpackage

// ---- rtl/ohp_edge.sv ----
`timescale 1ns/1ps

// Edge finder on a synchronous level
module ohp_edge
  import ohp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
  } ohp_edge_st_t;

  ohp_edge_st_t st_r;
  ohp_edge_st_t st_nxt;

  // Previous sample only
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = lvl;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise = lvl & ~st_r.prev;
  assign fall = ~lvl & st_r.prev;

endmodule

// ---- rtl/ohp_chan.sv ----
`timescale 1ns/1ps

// Pin roles and FIFO level counters of one serial channel
module ohp_chan
  import ohp_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [7:0]       feature_control_reg,
  input  wire logic [7:0]       enhanced_feature_reg,
  input  wire logic [7:0]       modem_control_reg,
  input  wire logic             rx_pin,
  input  wire logic             cts_n,
  input  wire logic             dsr_n,
  input  wire logic             tx_ser,
  input  wire logic             tx_ir,
  input  wire logic             tx_busy,
  input  wire logic             rx_stop,
  input  wire logic             host_push,
  input  wire logic             host_pop,
  input  wire logic             core_pop,
  input  wire logic             core_push,
  output logic                  tx_pin,
  output logic                  rts_n,
  output logic                  dtr_n,
  output logic                  rx_line,
  output logic                  tx_hold,
  output logic [LVL_W-1:0]      tx_lvl,
  output logic [LVL_W-1:0]      rx_lvl
);

  typedef struct packed {
    logic             tx_pin;
    logic             rts_n;
    logic             dtr_n;
    logic             rx_line;
    logic             tx_hold;
    logic [LVL_W-1:0] tx_lvl;
    logic [LVL_W-1:0] rx_lvl;
  } ohp_chan_st_t;

  ohp_chan_st_t st_r;
  ohp_chan_st_t st_nxt;
  logic         ir_on;
  logic         pair_dtr;
  logic         auto_out;
  logic         hs_out_n;

  // Pin role selection; outputs registered so pins never glitch
  always_comb begin
    st_nxt   = st_r;
    ir_on    = modem_control_reg[MCR_IR_EN_BIT];
    pair_dtr = modem_control_reg[MCR_PAIR_BIT];
    auto_out = feature_control_reg[FEATURE_CONTROL_REG_DIR_CTL_BIT] | enhanced_feature_reg[EFR_AUTO_OUT_BIT];
    // Direction control wins over flow control: asserted while sending
    hs_out_n = feature_control_reg[FEATURE_CONTROL_REG_DIR_CTL_BIT] ? ~tx_busy : rx_stop;
    st_nxt.rx_line = ir_on ? (rx_pin ^ feature_control_reg[FEATURE_CONTROL_REG_IR_INV_BIT]) : rx_pin;
    st_nxt.tx_pin  = ir_on ? tx_ir : tx_ser;
    st_nxt.rts_n   = (auto_out && !pair_dtr) ? hs_out_n : ~modem_control_reg[MCR_RTS_BIT];
    st_nxt.dtr_n   = (auto_out && pair_dtr) ? hs_out_n : ~modem_control_reg[MCR_DTR_BIT];
    st_nxt.tx_hold = enhanced_feature_reg[EFR_AUTO_IN_BIT] & (pair_dtr ? dsr_n : cts_n);
    // Level counters of the 64-byte FIFOs, guarded at both ends
    if (host_push && !core_pop && st_r.tx_lvl != FIFO_DEPTH) begin
      st_nxt.tx_lvl = st_r.tx_lvl + LVL_ONE;
    end else if (core_pop && !host_push && st_r.tx_lvl != LVL_ZERO) begin
      st_nxt.tx_lvl = st_r.tx_lvl - LVL_ONE;
    end
    if (core_push && !host_pop && st_r.rx_lvl != FIFO_DEPTH) begin
      st_nxt.rx_lvl = st_r.rx_lvl + LVL_ONE;
    end else if (host_pop && !core_push && st_r.rx_lvl != LVL_ZERO) begin
      st_nxt.rx_lvl = st_r.rx_lvl - LVL_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.tx_pin  <= 1'b1;
      st_r.rts_n   <= 1'b1;
      st_r.dtr_n   <= 1'b1;
      st_r.rx_line <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_pin  = st_r.tx_pin;
  assign rts_n   = st_r.rts_n;
  assign dtr_n   = st_r.dtr_n;
  assign rx_line = st_r.rx_line;
  assign tx_hold = st_r.tx_hold;
  assign tx_lvl  = st_r.tx_lvl;
  assign rx_lvl  = st_r.rx_lvl;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_ir_rx_invert: assert property (
    modem_control_reg[MCR_IR_EN_BIT] && feature_control_reg[FEATURE_CONTROL_REG_IR_INV_BIT] |=> rx_line == !$past(rx_pin))
    else $error("infrared receive not inverted");
  chk_auto_hold: assert property (
    enhanced_feature_reg[EFR_AUTO_IN_BIT] && !modem_control_reg[MCR_PAIR_BIT] && cts_n |=> tx_hold)
    else $error("transmit not held on deasserted clear-to-send");
  chk_tx_level_cap: assert property (
    tx_lvl <= FIFO_DEPTH && rx_lvl <= FIFO_DEPTH)
    else $error("fifo level beyond depth");

endmodule

// ---- rtl/ohp_port.sv ----
`timescale 1ns/1ps

// Overview of operation
// - Address bits 3:0 pick channel register
// - Address bits 6:4 pick the channel
// - Address bit 7 selects global registers
// - Eight-bit bidirectional data bus
// - Mode pin high selects two-strobe mode
// - Read strobe fall places register byte
// - Write strobe closing edge stores byte
// - Mode low: write strobe is direction
// - Mode low: chip select is strobe
// - One shared open-drain interrupt output
// - Global register shows all channel interrupts
// - Each channel has 64-byte FIFOs
// - Receive idles high, infrared inversion bit 4
// - Transmit pin carries serial or infrared
// - Handshake outputs: flow or direction control
// - Enhanced bits 6 and 7 enable auto
// - First eight registers keep classic layout
module ohp_port
  import ohp_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    bus_mode_sel,
  input  wire logic                    chip_sel_n,
  input  wire logic                    read_strobe_n,
  input  wire logic                    write_strobe_n,
  input  wire logic [7:0]              addr,
  input  wire logic [7:0]              data_in,
  output logic [7:0]                   data_out,
  output logic                         data_oe_n,
  output logic                         irq_out,
  output logic                         irq_oe_n,
  input  wire logic [NUM_CH-1:0]       chan_irq,
  input  wire logic [NUM_CH-1:0][7:0]  rx_core_byte,
  output logic [NUM_CH-1:0]            rx_pop,
  output logic [NUM_CH-1:0]            tx_push,
  output logic [7:0]                   tx_byte,
  input  wire logic [NUM_CH-1:0]       core_tx_pop,
  input  wire logic [NUM_CH-1:0]       core_rx_push,
  input  wire logic [NUM_CH-1:0]       rx_pin,
  input  wire logic [NUM_CH-1:0]       cts_n,
  input  wire logic [NUM_CH-1:0]       dsr_n,
  input  wire logic [NUM_CH-1:0]       tx_ser,
  input  wire logic [NUM_CH-1:0]       tx_ir,
  input  wire logic [NUM_CH-1:0]       tx_busy,
  input  wire logic [NUM_CH-1:0]       rx_stop,
  output logic [NUM_CH-1:0]            tx_pin,
  output logic [NUM_CH-1:0]            rts_n,
  output logic [NUM_CH-1:0]            dtr_n,
  output logic [NUM_CH-1:0]            rx_line,
  output logic [NUM_CH-1:0]            tx_hold
);

  typedef struct packed {
    logic [7:0]        dout;
    logic              oe_n;
    logic              irq_oe_n;
    logic              glob;
    logic [2:0]        ch;
    logic [3:0]        idx;
    logic [7:0]        wdata;
    logic [NUM_CH-1:0] tx_push;
    logic [7:0]        tx_byte;
    logic [NUM_CH-1:0] rx_pop;
    ohp_bank_t         bank;
  } ohp_port_st_t;

  ohp_port_st_t st_r;
  ohp_port_st_t st_nxt;

  logic                          rd_act;
  logic                          wr_act;
  logic                          rd_start;
  logic                          rd_end;
  logic                          wr_start;
  logic                          wr_end;
  logic [2:0]                    a_ch;
  logic [3:0]                    a_idx;
  logic                          a_glob;
  logic [7:0]                    rd_val;
  logic [7:0]                    lsr_val;
  logic [NUM_CH-1:0][LVL_W-1:0]  tx_lvl;
  logic [NUM_CH-1:0][LVL_W-1:0]  rx_lvl;

  // Address fields of the current bus cycle
  assign a_idx  = addr[IDX_MSB:IDX_LSB];
  assign a_ch   = addr[CH_MSB:CH_LSB];
  assign a_glob = addr[GLOBAL_BIT];

  // Strobe decode for both bus modes; the write level is the same in both
  always_comb begin
    if (bus_mode_sel) begin
      // Chip select gates both strobes, so a deselected bus is idle
      rd_act = !chip_sel_n && !read_strobe_n;
      wr_act = !chip_sel_n && !write_strobe_n;
    end else begin
      // Read strobe pin is ignored here; the host ties it high
      rd_act = !chip_sel_n && write_strobe_n;
      wr_act = !chip_sel_n && !write_strobe_n;
    end
  end

  ohp_edge u_rd_edge (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .lvl     (rd_act),
    .rise    (rd_start),
    .fall    (rd_end)
  );

  ohp_edge u_wr_edge (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .lvl     (wr_act),
    .rise    (wr_start),
    .fall    (wr_end)
  );

  // Line status built from the channel FIFO levels
  always_comb begin
    lsr_val                   = REG_RESET;
    lsr_val[LSR_RX_RDY_BIT]   = rx_lvl[a_ch] != LVL_ZERO;
    lsr_val[LSR_TX_ROOM_BIT]  = tx_lvl[a_ch] != FIFO_DEPTH;
    lsr_val[LSR_TX_EMPTY_BIT] = tx_lvl[a_ch] == LVL_ZERO;
  end

  // Read value for the address on the bus; classic layout in indices 0-7
  always_comb begin
    rd_val = REG_RESET;
    if (a_glob) begin
      if (a_idx == GREG_INT_SRC) begin
        rd_val = chan_irq;
      end
    end else begin
      case (a_idx)
        REG_HOLD:      rd_val = rx_core_byte[a_ch];
        REG_LINE_STAT: rd_val = lsr_val;
        REG_TX_LEVEL:  rd_val = {1'b0, tx_lvl[a_ch]};
        REG_RX_LEVEL:  rd_val = {1'b0, rx_lvl[a_ch]};
        default:       rd_val = st_r.bank[a_ch][a_idx];
      endcase
    end
  end

  // Bus cycle engine
  always_comb begin
    st_nxt         = st_r;
    st_nxt.tx_push = '0;
    st_nxt.rx_pop  = '0;
    // Any channel pending pulls the shared line low
    st_nxt.irq_oe_n = ~(|chan_irq);
    // Address is taken at the opening edge of either strobe
    if (rd_start || wr_start) begin
      st_nxt.glob = a_glob;
      st_nxt.ch   = a_ch;
      st_nxt.idx  = a_idx;
    end
    // Read: byte placed at the opening edge, bus released at the close
    if (rd_start) begin
      st_nxt.dout = rd_val;
      st_nxt.oe_n = 1'b0;
      if (!a_glob && a_idx == REG_HOLD && rx_lvl[a_ch] != LVL_ZERO) begin
        st_nxt.rx_pop[a_ch] = 1'b1;
      end
    end else if (rd_end) begin
      st_nxt.oe_n = 1'b1;
    end
    // Write: data tracked while active, committed at the closing edge
    if (wr_act) begin
      st_nxt.wdata = data_in;
    end
    if (wr_end && !st_r.glob) begin
      case (st_r.idx)
        REG_HOLD: begin
          // A full FIFO drops the byte, as a classic part would
          if (tx_lvl[st_r.ch] != FIFO_DEPTH) begin
            st_nxt.tx_push[st_r.ch] = 1'b1;
            st_nxt.tx_byte          = st_r.wdata;
          end
        end
        REG_LINE_STAT, REG_TX_LEVEL, REG_RX_LEVEL: begin
          st_nxt.bank = st_r.bank;                                 // Read-only status
        end
        default: begin
          st_nxt.bank[st_r.ch][st_r.idx] = st_r.wdata;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r          <= '0;
      st_r.oe_n     <= 1'b1;
      st_r.irq_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Open-drain line: level is always low, only the enable moves
  assign irq_out   = 1'b0;
  assign irq_oe_n  = st_r.irq_oe_n;
  assign data_out  = st_r.dout;
  assign data_oe_n = st_r.oe_n;
  assign tx_push   = st_r.tx_push;
  assign tx_byte   = st_r.tx_byte;
  assign rx_pop    = st_r.rx_pop;

  // Per-channel pin roles and FIFO accounting
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      ohp_chan u_chan (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .feature_control_reg      (st_r.bank[g][REG_FEAT_CTL]),
        .enhanced_feature_reg       (st_r.bank[g][REG_ENH_FEAT]),
        .modem_control_reg       (st_r.bank[g][REG_MODEM_CTL]),
        .rx_pin    (rx_pin[g]),
        .cts_n     (cts_n[g]),
        .dsr_n     (dsr_n[g]),
        .tx_ser    (tx_ser[g]),
        .tx_ir     (tx_ir[g]),
        .tx_busy   (tx_busy[g]),
        .rx_stop   (rx_stop[g]),
        .host_push (st_r.tx_push[g]),
        .host_pop  (st_r.rx_pop[g]),
        .core_pop  (core_tx_pop[g]),
        .core_push (core_rx_push[g]),
        .tx_pin    (tx_pin[g]),
        .rts_n     (rts_n[g]),
        .dtr_n     (dtr_n[g]),
        .rx_line   (rx_line[g]),
        .tx_hold   (tx_hold[g]),
        .tx_lvl    (tx_lvl[g]),
        .rx_lvl    (rx_lvl[g])
      );
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Bus drive tied to the read cycle
  chk_rd_drive_bus: assert property (
    rd_start |=> !data_oe_n && data_out == $past(rd_val))
    else $error("read did not place byte on bus");
  chk_bus_release: assert property (
    rd_end |=> data_oe_n)
    else $error("bus not released after read");
  chk_no_idle_drive: assert property (
    !data_oe_n |-> $past(rd_act))
    else $error("bus driven outside a read");
  chk_single_read: assert property (
    !bus_mode_sel && !chip_sel_n && write_strobe_n && $past(chip_sel_n)
      && !$past(bus_mode_sel) |=> !data_oe_n)
    else $error("single-strobe read not started");
  chk_wr_commit: assert property (
    wr_end && !st_r.glob && st_r.idx == REG_FEAT_CTL
      |=> st_r.bank[$past(st_r.ch)][REG_FEAT_CTL] == $past(st_r.wdata))
    else $error("write not stored at closing edge");
  chk_chan_route: assert property (
    |tx_push |-> tx_push == (8'h01 << st_r.ch) && tx_byte == st_r.wdata)
    else $error("push sent to wrong channel");
  chk_global_no_push: assert property (
    wr_end && st_r.glob |=> tx_push == 8'h00)
    else $error("global write reached a channel");
  chk_gisr_read: assert property (
    rd_start && a_glob && a_idx == GREG_INT_SRC |=> data_out == $past(chan_irq))
    else $error("interrupt source read wrong");
  chk_irq_pull: assert property (
    (|chan_irq) |=> !irq_oe_n && irq_out == 1'b0)
    else $error("interrupt line not pulled");
  chk_irq_idle: assert property (
    chan_irq == 8'h00 |=> irq_oe_n)
    else $error("interrupt line pulled with nothing pending");

  cov_two_strobe_read: cover property (
    bus_mode_sel && rd_start ##[1:20] rd_end);
  cov_single_write: cover property (
    !bus_mode_sel && wr_start ##[1:20] wr_end);
  cov_global_read: cover property (rd_start && a_glob);
  cov_fifo_push: cover property (|tx_push);

endmodule

// ---- tb/ohp_host.sv ----
`timescale 1ns/1ps

// Host processor model on the parallel bus
module ohp_host (
  input  wire logic       sys_clk,
  input  wire logic [7:0] bus_rd,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  output logic            wdrv
);
  // Idle bus: no strobe, data released
  initial begin
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    addr  = 8'h00;
    wdata = 8'h00;
    wdrv  = 1'b0;
  end

  // One bus cycle; slow stretches the strobe to act as a sluggish host
  task automatic xfer(input logic md, input logic wr, input logic [7:0] a,
                      input logic [7:0] d, input int slow, output logic [7:0] q);
    @(posedge sys_clk);
    #1;
    addr  = a;
    wdata = d;
    wdrv  = wr;
    cs_n  = 1'b0;
    rd_n  = !(md && !wr);
    wr_n  = !wr;
    repeat (3 + slow) @(posedge sys_clk);
    q = bus_rd;
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    wdrv = 1'b0;
    // Gap also covers the late write commit
    repeat (2) @(posedge sys_clk);
  endtask
endmodule

// ---- tb/octal_uart_host_bus_port_bench.sv ----
`timescale 1ns/1ps

// Self-checking bench for the host bus port
module octal_uart_host_bus_port_bench;
  import ohp_pkg::*;
  logic                   sys_clk, reset_n, bus_mode_sel, cs_n, rd_n, wr_n, wdrv;
  logic [7:0]             addr, wdata, wire_d, data_out, tx_byte, q;
  logic                   data_oe_n, irq_out, irq_oe_n;
  logic [NUM_CH-1:0]      chan_irq, rx_pop, tx_push, rx_pin, cts_n, dsr_n;
  logic [NUM_CH-1:0]      tx_ser, tx_ir, tx_busy, rx_stop, tx_pin, rts_n, dtr_n;
  logic [NUM_CH-1:0]      rx_line, tx_hold;
  logic [NUM_CH-1:0][7:0] rx_core_byte;
  logic [7:0]             m_reg [8][16];
  int                     m_txl [8];
  int                     m_rxl [8];
  logic [7:0]             exp_tx [$];
  logic [NUM_CH-1:0]      rx_push_in;
  int                     err_count, total_checks, cyc, n_push, n_pop;
  localparam logic [3:0]  IDX_TAB [10] = '{1, 2, 3, 4, 6, 7, 12, 13, 14, 15};

  // Shared data wire: released lines show the inverse, never a stale value
  assign wire_d = !data_oe_n ? data_out : (wdrv ? wdata : ~wdata);

  ohp_host i_host (.sys_clk(sys_clk), .bus_rd(wire_d), .cs_n(cs_n), .rd_n(rd_n),
                   .wr_n(wr_n), .addr(addr), .wdata(wdata), .wdrv(wdrv));

  ohp_port i_ohp_port (.sys_clk(sys_clk), .reset_n(reset_n), .bus_mode_sel(bus_mode_sel),
    .chip_sel_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr(addr),
    .data_in(wire_d), .data_out(data_out), .data_oe_n(data_oe_n), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n), .chan_irq(chan_irq), .rx_core_byte(rx_core_byte),
    .rx_pop(rx_pop), .tx_push(tx_push), .tx_byte(tx_byte), .core_tx_pop(8'h00),
    .core_rx_push(rx_push_in), .rx_pin(rx_pin), .cts_n(cts_n), .dsr_n(dsr_n),
    .tx_ser(tx_ser), .tx_ir(tx_ir), .tx_busy(tx_busy), .rx_stop(rx_stop),
    .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n), .rx_line(rx_line),
    .tx_hold(tx_hold));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Cycle ceiling and FIFO pulse counting
  always @(posedge sys_clk) begin
    cyc++;
    n_push += $countones(tx_push);
    n_pop  += $countones(rx_pop);
    // Each accepted hold write must surface once, in order
    if (|tx_push)
      chk_bus("tx_byte", exp_tx.pop_front(), tx_byte);
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic results;
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_bus(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // Reference register file: hold pushes, read-only and global writes dropped
  task automatic do_wr(input logic md, input logic [7:0] a, input logic [7:0] d);
    #1;
    bus_mode_sel = md;
    // Model first, so the push pulse finds its expected byte queued
    if (!a[7]) begin
      if (a[3:0] == 4'h0) begin
        if (m_txl[a[6:4]] < 64) begin
          m_txl[a[6:4]]++;
          exp_tx.push_back(d);
        end
      end else if (a[3:0] != 4'h5 && a[3:0] != 4'ha && a[3:0] != 4'hb)
        m_reg[a[6:4]][a[3:0]] = d;
    end
    i_host.xfer(md, 1'b1, a, d, $urandom_range(0, 2), q);
  endtask

  task automatic do_rd(input logic md, input logic [7:0] a);
    logic [7:0] e;
    #1;
    bus_mode_sel = md;
    if (a[7])
      e = (a[3:0] == 4'h0) ? chan_irq : 8'h00;
    else if (a[3:0] == 4'h0) begin
      e = rx_core_byte[a[6:4]];
      if (m_rxl[a[6:4]] > 0)
        m_rxl[a[6:4]]--;
    end else if (a[3:0] == 4'ha)
      e = 8'(m_txl[a[6:4]]);
    else if (a[3:0] == 4'hb)
      e = 8'(m_rxl[a[6:4]]);
    else if (a[3:0] == 4'h5)
      e = {1'b0, m_txl[a[6:4]] == 0, m_txl[a[6:4]] != 64, 4'h0, m_rxl[a[6:4]] != 0};
    else
      e = m_reg[a[6:4]][a[3:0]];
    i_host.xfer(md, 1'b0, a, 8'h00, $urandom_range(0, 2), q);
    chk_bus("read_data", e, q);
  endtask

  // Pin role reference for all channels
  task automatic chk_pins;
    logic [7:0] e_tx, e_rx, e_rts, e_dtr, e_hold, m, f, x;
    for (int c = 0; c < 8; c++) begin
      m = m_reg[c][4];
      f = m_reg[c][8];
      x = m_reg[c][9];
      e_tx[c]   = m[6] ? tx_ir[c] : tx_ser[c];
      e_rx[c]   = rx_pin[c] ^ (m[6] & f[4]);
      e_rts[c]  = (!m[2] && (f[5] || x[6])) ? (f[5] ? !tx_busy[c] : rx_stop[c]) : !m[1];
      e_dtr[c]  = (m[2] && (f[5] || x[6])) ? (f[5] ? !tx_busy[c] : rx_stop[c]) : !m[0];
      e_hold[c] = x[7] & (m[2] ? dsr_n[c] : cts_n[c]);
    end
    chk_pin("tx_pin", e_tx, tx_pin);
    chk_pin("rx_line", e_rx, rx_line);
    chk_pin("rts_n", e_rts, rts_n);
    chk_pin("dtr_n", e_dtr, dtr_n);
    chk_pin("tx_hold", e_hold, tx_hold);
  endtask

  task automatic rand_pins;
    {rx_pin, cts_n, dsr_n, tx_ser} = $urandom;
    {tx_ir, tx_busy, rx_stop} = 24'($urandom);
    rx_core_byte = {$urandom, $urandom};
  endtask

  initial begin
    logic [2:0] c;
    void'($urandom(88435));
    for (int i = 0; i < 8; i++)
      for (int j = 0; j < 16; j++)
        m_reg[i][j] = 8'h00;
    reset_n = 1'b0;
    bus_mode_sel = 1'b1;
    chan_irq = 8'h00;
    rx_push_in = 8'h00;
    rand_pins();
    repeat (3) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    // Interrupt line follows the channels; data bus stays released
    for (int i = 0; i < 20; i++) begin
      chan_irq = ($urandom_range(0, 2) == 0) ? 8'h00 : 8'($urandom);
      @(posedge sys_clk);
      #1;
      chk_pin("irq_oe_n", {7'h00, ~|chan_irq}, {7'h00, irq_oe_n});
      chk_pin("irq_out", 8'h00, {7'h00, irq_out});
      chk_pin("data_oe_n", 8'h01, {7'h00, data_oe_n});
    end
    // Storage round trips, both bus modes mixed
    for (int i = 0; i < 24; i++) begin
      c = 3'($urandom);
      do_wr(i[0], {1'b0, c, IDX_TAB[$urandom_range(0, 9)]}, 8'($urandom));
      do_rd(i[1], {1'b0, c, addr[3:0]});
    end
    // Global space and read-only places
    do_wr(1'b0, 8'h80, 8'hff);
    do_rd(1'b0, 8'hf0);
    do_rd(1'b1, 8'h85);
    do_wr(1'b1, 8'h3b, 8'h5a);
    do_rd(1'b1, 8'h3b);
    // Fill one transmit FIFO past its depth
    c = 3'($urandom);
    n_push = 0;
    n_pop = 0;
    for (int j = 0; j < 65; j++)
      do_wr(1'b1, {1'b0, c, 4'h0}, 8'(j));
    chk_pin("push_count", 8'd64, 8'(n_push));
    do_rd(1'b0, {1'b0, c, 4'ha});
    do_rd(1'b1, {1'b0, c, 4'h0});
    chk_pin("pop_count", 8'h00, 8'(n_pop));
    // Core adds three receive bytes; level, status and one pop follow
    #1;
    m_rxl[c] = 3;
    rx_push_in[c] = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    rx_push_in = 8'h00;
    do_rd(1'b1, {1'b0, c, 4'hb});
    do_rd(1'b0, {1'b0, c, 4'h5});
    do_rd(1'b1, {1'b0, c, 4'h0});
    chk_pin("pop_count", 8'h01, 8'(n_pop));
    do_rd(1'b1, {1'b0, c, 4'hb});
    // Pin roles under random modem, feature and enhanced settings
    for (int i = 0; i < 32; i++) begin
      c = 3'($urandom);
      do_wr(1'b1, {1'b0, c, 4'h4}, 8'($urandom));
      do_wr(1'b0, {1'b0, c, 4'h8}, 8'($urandom));
      do_wr(1'b1, {1'b0, c, 4'h9}, 8'($urandom));
      for (int k = 0; k < 3; k++) begin
        #1;
        rand_pins();
        @(posedge sys_clk);
        #1;
        chk_pins();
      end
    end
    results();
  end
endmodule
